// [shared/ufc_pkg.sv]
// package for the uart flow control and trigger level block
package ufc_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] UFC_OFS_FEAT     = 8'h00;
  localparam logic [7:0] UFC_OFS_TXLVL    = 8'h04;
  localparam logic [7:0] UFC_OFS_RXLVL    = 8'h08;
  localparam logic [7:0] UFC_OFS_FHIGH    = 8'h0C;
  localparam logic [7:0] UFC_OFS_FLOW     = 8'h10;
  localparam logic [7:0] UFC_OFS_PRES     = 8'h14;
  localparam logic [7:0] UFC_OFS_CHAR0    = 8'h18;
  localparam logic [7:0] UFC_OFS_CHAR1    = 8'h1C;
  localparam logic [7:0] UFC_OFS_CHAR2    = 8'h20;
  localparam logic [7:0] UFC_OFS_CHAR3    = 8'h24;
  localparam logic [7:0] UFC_OFS_CTRL     = 8'h28;
  localparam logic [7:0] UFC_OFS_FCRLVL   = 8'h2C;
  localparam logic [7:0] UFC_OFS_ISTAT    = 8'h30;
  localparam logic [7:0] UFC_OFS_IMASK    = 8'h34;
  localparam logic [7:0] UFC_OFS_STATE    = 8'h38;

  // field positions
  localparam int UFC_FEAT_TX1  = 3;
  localparam int UFC_FEAT_TX2  = 2;
  localparam int UFC_FEAT_RX1  = 1;
  localparam int UFC_FEAT_RX2  = 0;
  localparam int UFC_CTRL_F128 = 0;
  localparam int UFC_CTRL_ARTS = 1;
  localparam int UFC_PRES_W    = 4;
  localparam int UFC_NIRQ      = 5;
  localparam int UFC_IRQ_TX    = 0;
  localparam int UFC_IRQ_RX    = 1;
  localparam int UFC_IRQ_PAUSE = 2;
  localparam int UFC_IRQ_RESUM = 3;
  localparam int UFC_IRQ_FLOW  = 4;

  // reset values
  localparam logic [3:0]  UFC_FEAT_RST  = 4'h0;
  localparam logic [7:0]  UFC_LVL_RST   = 8'h00;
  localparam logic [3:0]  UFC_PRES_RST  = 4'h0;
  localparam logic [1:0]  UFC_CTRL_RST  = 2'h0;
  localparam logic [31:0] UFC_SMALL_RST = 32'h0000_0000;
  localparam logic [7:0]  UFC_CHAR_RST  = 8'h00;

  // level limits
  localparam logic [7:0] UFC_LVL_MIN = 8'h01;
  localparam logic [7:0] UFC_LVL_MAX = 8'h80;

  // host register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ufc_req_t;

  // flow state
  typedef enum {UFC_FLOW_RUN, UFC_FLOW_HELD} ufc_flow_t;

endpackage

// [hw/ufc_top.sv]
// uart software flow control selection and fifo level registers
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

// Function
// - tx bits choose which pause/resume pairs sent
// - rx bits choose which pair is compared
// - rx 11, one tx pair: accept either
// - all ones: send both, need both matched
// - hold 8-bit transmit trigger level
// - hold 8-bit receive trigger level
// - levels programmable one to 128 entries
// - 0x00/0x01 mean one, 0x80 means 128
// - hold 8-bit high flow threshold
// - hold 8-bit low flow threshold
// - compare occupancy to thresholds, stop/restart
// - levels apply only in 128 fifo mode
// - 4-bit prescaler, reset zero, upper reserved
// - selection low nibble, cleared at reset
// - auto request high above trigger, low below trigger minus one
module ufc_top (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // host register port
  input  wire ufc_pkg::ufc_req_t req,
  output logic [31:0]            rdata,
  output logic                   irq,
  // fifo occupancy from the data path
  input  wire logic [7:0]        tx_fill,
  input  wire logic [7:0]        rx_fill,
  // received character stream
  input  wire logic              rx_char_vld,
  input  wire logic [7:0]        rx_char,
  // decoded settings to the data path
  output logic                   tx_send_first,
  output logic                   tx_send_second,
  output logic [3:0]             clock_prescaler,
  // flow control outputs
  output logic                   tx_irq_cond,
  output logic                   rx_irq_cond,
  output logic                   remote_pause_req,
  output logic                   remote_resume_req,
  output logic                   local_tx_paused,
  output logic                   rts_req
);
  import ufc_pkg::*;

  logic [3:0]  feat_r;
  logic [7:0]  txlvl_r;
  logic [7:0]  rxlvl_r;
  logic [7:0]  fhigh_r;
  logic [7:0]  flow_r;
  logic [3:0]  pres_r;
  logic [7:0]  first_resume_char_r;
  logic [7:0]  second_resume_char_r;
  logic [7:0]  first_pause_char_r;
  logic [7:0]  second_pause_char_r;
  logic [1:0]  ctrl_r;
  logic [31:0] fcrlvl_r;
  logic [UFC_NIRQ-1:0] istat_r;
  logic [UFC_NIRQ-1:0] imask_r;
  logic [31:0] rdata_nxt;
  ufc_flow_t   flow_st_r;
  logic        tx_paused_r;
  logic        rts_r;
  logic        pend_resume_r;
  logic        pend_pause_r;
  logic        tx_cond_d_r;
  logic        rx_cond_d_r;
  logic        held_d_r;
  logic        sel_first_r;
  logic        sel_second_r;

  // effective levels: 0 and 1 give one, above 0x80 clamps to 128
  // clamping keeps undefined codes away from the comparators
  function automatic logic [7:0] eff_lvl(input logic [7:0] v);
    if (v < UFC_LVL_MIN) begin
      eff_lvl = UFC_LVL_MIN;
    end else if (v > UFC_LVL_MAX) begin
      eff_lvl = UFC_LVL_MAX;
    end else begin
      eff_lvl = v;
    end
  endfunction

  // in 32 fifo mode the small-fifo level bytes supply the levels
  // so software can switch modes without reprogramming anything
  logic [7:0] tx_lvl;
  logic [7:0] rx_lvl;
  logic [7:0] hi_lvl;
  logic [7:0] lo_lvl;
  logic       wr_hit;
  assign tx_lvl = ctrl_r[UFC_CTRL_F128] ? eff_lvl(txlvl_r)
                                        : eff_lvl(fcrlvl_r[7:0]);
  assign rx_lvl = ctrl_r[UFC_CTRL_F128] ? eff_lvl(rxlvl_r)
                                        : eff_lvl(fcrlvl_r[15:8]);
  assign hi_lvl = ctrl_r[UFC_CTRL_F128] ? eff_lvl(fhigh_r)
                                        : eff_lvl(fcrlvl_r[23:16]);
  assign lo_lvl = ctrl_r[UFC_CTRL_F128] ? eff_lvl(flow_r)
                                        : eff_lvl(fcrlvl_r[31:24]);
  assign wr_hit = req.wr;

  // configuration registers written by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feat_r   <= UFC_FEAT_RST;
      txlvl_r  <= UFC_LVL_RST;
      rxlvl_r  <= UFC_LVL_RST;
      fhigh_r  <= UFC_LVL_RST;
      flow_r   <= UFC_LVL_RST;
      pres_r   <= UFC_PRES_RST;
      ctrl_r   <= UFC_CTRL_RST;
      fcrlvl_r <= UFC_SMALL_RST;
      imask_r  <= '0;
    end else if (wr_hit) begin
      case (req.addr)
        UFC_OFS_FEAT:   feat_r   <= req.wdata[3:0];
        UFC_OFS_TXLVL:  txlvl_r  <= req.wdata[7:0];
        UFC_OFS_RXLVL:  rxlvl_r  <= req.wdata[7:0];
        UFC_OFS_FHIGH:  fhigh_r  <= req.wdata[7:0];
        UFC_OFS_FLOW:   flow_r   <= req.wdata[7:0];
        UFC_OFS_PRES:   pres_r   <= req.wdata[3:0];
        UFC_OFS_CTRL:   ctrl_r   <= req.wdata[1:0];
        UFC_OFS_FCRLVL: fcrlvl_r <= req.wdata;
        UFC_OFS_IMASK:  imask_r  <= req.wdata[UFC_NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // flow characters held apart from the level registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_resume_char_r  <= UFC_CHAR_RST;
      second_resume_char_r <= UFC_CHAR_RST;
      first_pause_char_r   <= UFC_CHAR_RST;
      second_pause_char_r  <= UFC_CHAR_RST;
    end else if (wr_hit) begin
      case (req.addr)
        UFC_OFS_CHAR0: first_resume_char_r  <= req.wdata[7:0];
        UFC_OFS_CHAR1: second_resume_char_r <= req.wdata[7:0];
        UFC_OFS_CHAR2: first_pause_char_r   <= req.wdata[7:0];
        UFC_OFS_CHAR3: second_pause_char_r  <= req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // receive matching; combined mode needs two chars in order
  logic rx1;
  logic rx2;
  logic both;
  logic m_r1;
  logic m_r2;
  logic m_p1;
  logic m_p2;
  logic hit_resume;
  logic hit_pause;
  logic [1:0] half_r; // bit0 first resume seen, bit1 first pause seen
  assign rx1  = feat_r[UFC_FEAT_RX1];
  assign rx2  = feat_r[UFC_FEAT_RX2];
  assign both = &feat_r;
  assign m_r1 = rx_char_vld && (rx_char == first_resume_char_r);
  assign m_r2 = rx_char_vld && (rx_char == second_resume_char_r);
  assign m_p1 = rx_char_vld && (rx_char == first_pause_char_r);
  assign m_p2 = rx_char_vld && (rx_char == second_pause_char_r);

  always_comb begin
    hit_resume = 1'b0;
    hit_pause  = 1'b0;
    if (both) begin
      hit_resume = m_r2 && half_r[0];
      hit_pause  = m_p2 && half_r[1];
    end else if (rx1 && rx2) begin
      hit_resume = m_r1 || m_r2;
      hit_pause  = m_p1 || m_p2;
    end else if (rx1) begin
      hit_resume = m_r1;
      hit_pause  = m_p1;
    end else if (rx2) begin
      hit_resume = m_r2;
      hit_pause  = m_p2;
    end
  end

  // partial match of a combined pair; any other char breaks it
  // idle cycles with no valid char keep the half match
  always_ff @(posedge clk) begin
    if (!rst_n || !both) begin
      half_r <= 2'b00;
    end else if (rx_char_vld) begin
      half_r <= {m_p1, m_r1};
    end
  end

  // remote pause state of our own transmitter
  always_ff @(posedge clk) begin
    if (!rst_n || !(rx1 || rx2)) begin
      tx_paused_r <= 1'b0;
    end else if (hit_pause) begin
      tx_paused_r <= 1'b1;
    end else if (hit_resume) begin
      tx_paused_r <= 1'b0;
    end
  end

  // stop/restart remote: hysteresis between high and low levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flow_st_r <= UFC_FLOW_RUN;
    end else begin
      case (flow_st_r)
        UFC_FLOW_RUN:
          if (rx_fill >= hi_lvl) flow_st_r <= UFC_FLOW_HELD;
        UFC_FLOW_HELD:
          if (rx_fill <= lo_lvl) flow_st_r <= UFC_FLOW_RUN;
        default: flow_st_r <= UFC_FLOW_RUN;
      endcase
    end
  end

  // pending in-band chars; only meaningful when a tx pair is chosen
  logic tx_any;
  logic held;
  assign tx_any = feat_r[UFC_FEAT_TX1] || feat_r[UFC_FEAT_TX2];
  assign held   = (flow_st_r == UFC_FLOW_HELD);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_d_r      <= 1'b0;
      pend_pause_r  <= 1'b0;
      pend_resume_r <= 1'b0;
      sel_first_r   <= 1'b0;
      sel_second_r  <= 1'b0;
    end else begin
      held_d_r      <= held;
      pend_pause_r  <= tx_any && held && !held_d_r;
      pend_resume_r <= tx_any && !held && held_d_r;
      sel_first_r   <= feat_r[UFC_FEAT_TX1];
      sel_second_r  <= feat_r[UFC_FEAT_TX2];
    end
  end

  // auto request: up above rx trigger, down below trigger minus one
  // the one-entry gap keeps the request from chattering at the level
  always_ff @(posedge clk) begin
    if (!rst_n || !ctrl_r[UFC_CTRL_ARTS]) begin
      rts_r <= 1'b0;
    end else if (rx_fill > rx_lvl) begin
      rts_r <= 1'b1;
    end else if (rx_fill < rx_lvl - 8'h01) begin
      rts_r <= 1'b0;
    end
  end

  // interrupt conditions from fifo levels
  logic tx_cond;
  logic rx_cond;
  assign tx_cond = (tx_fill <= tx_lvl);
  assign rx_cond = (rx_fill >= rx_lvl);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_cond_d_r <= 1'b0;
      rx_cond_d_r <= 1'b0;
    end else begin
      tx_cond_d_r <= tx_cond;
      rx_cond_d_r <= rx_cond;
    end
  end

  // sticky events, set wins over a write-one clear
  // so an event in the clearing cycle is never lost
  logic [UFC_NIRQ-1:0] ev;
  assign ev[UFC_IRQ_TX]    = tx_cond && !tx_cond_d_r;
  assign ev[UFC_IRQ_RX]    = rx_cond && !rx_cond_d_r;
  assign ev[UFC_IRQ_PAUSE] = hit_pause;
  assign ev[UFC_IRQ_RESUM] = hit_resume;
  assign ev[UFC_IRQ_FLOW]  = held != held_d_r;
  genvar gi;
  generate
    for (gi = 0; gi < UFC_NIRQ; gi++) begin : g_irq
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          istat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          istat_r[gi] <= 1'b1;
        end else if (wr_hit && req.addr == UFC_OFS_ISTAT
                     && req.wdata[gi]) begin
          istat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (req.addr)
      UFC_OFS_FEAT:   rdata_nxt[3:0] = feat_r;
      UFC_OFS_TXLVL:  rdata_nxt[7:0] = txlvl_r;
      UFC_OFS_RXLVL:  rdata_nxt[7:0] = rxlvl_r;
      UFC_OFS_FHIGH:  rdata_nxt[7:0] = fhigh_r;
      UFC_OFS_FLOW:   rdata_nxt[7:0] = flow_r;
      UFC_OFS_PRES:   rdata_nxt[3:0] = pres_r;
      UFC_OFS_CHAR0:  rdata_nxt[7:0] = first_resume_char_r;
      UFC_OFS_CHAR1:  rdata_nxt[7:0] = second_resume_char_r;
      UFC_OFS_CHAR2:  rdata_nxt[7:0] = first_pause_char_r;
      UFC_OFS_CHAR3:  rdata_nxt[7:0] = second_pause_char_r;
      UFC_OFS_CTRL:   rdata_nxt[1:0] = ctrl_r;
      UFC_OFS_FCRLVL: rdata_nxt      = fcrlvl_r;
      UFC_OFS_ISTAT:  rdata_nxt[UFC_NIRQ-1:0] = istat_r;
      UFC_OFS_IMASK:  rdata_nxt[UFC_NIRQ-1:0] = imask_r;
      UFC_OFS_STATE:  rdata_nxt[2:0] = {rts_r, tx_paused_r, held};
      default: ;
    endcase
  end

  // read data registered, valid only the cycle after the strobe
  // zero otherwise, so a stale word never looks like an answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // outputs
  assign irq               = |(istat_r & imask_r);
  assign tx_send_first     = sel_first_r;
  assign tx_send_second    = sel_second_r;
  assign clock_prescaler   = pres_r;
  assign tx_irq_cond       = tx_cond_d_r;
  assign rx_irq_cond       = rx_cond_d_r;
  assign remote_pause_req  = pend_pause_r;
  assign remote_resume_req = pend_resume_r;
  assign local_tx_paused   = tx_paused_r;
  assign rts_req           = rts_r;

endmodule // ufc_top

// [verif/ufc_chk.sv]
// assertion checker for the uart flow control block
`timescale 1ns/1ps
module ufc_chk (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // host port and inputs
  input wire ufc_pkg::ufc_req_t req,
  input wire logic [31:0]       rdata,
  input wire logic [7:0]        tx_fill,
  input wire logic [7:0]        rx_fill,
  input wire logic              rx_char_vld,
  input wire logic [7:0]        rx_char,
  // observed outputs
  input wire logic              tx_send_first,
  input wire logic              tx_send_second,
  input wire logic [3:0]        clock_prescaler,
  input wire logic              tx_irq_cond,
  input wire logic              rx_irq_cond,
  input wire logic              local_tx_paused,
  input wire logic              rts_req,
  input wire logic              remote_pause_req
);
  import ufc_pkg::*;
  logic [31:0] regs_r [16];
  logic [1:0]  age_r;
  logic [7:0]  txl;
  logic [7:0]  rxl;
  logic        m128;
  logic        arts;
  function automatic logic [7:0] lvl(input logic [7:0] v);
    return (v == 8'h00) ? UFC_LVL_MIN : ((v > UFC_LVL_MAX) ? UFC_LVL_MAX : v);
  endfunction
  // shadow of host writes; age saturates so settled outputs can be judged
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regs_r <= '{default: 32'h0000_0000};
      age_r  <= 2'h3;
    end else begin
      if (req.wr) regs_r[req.addr[5:2]] <= req.wdata;
      age_r <= req.wr ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
    end
  end
  // effective levels in the large fifo mode
  assign txl  = lvl(regs_r[1][7:0]);
  assign rxl  = lvl(regs_r[2][7:0]);
  assign m128 = regs_r[10][UFC_CTRL_F128];
  assign arts = regs_r[10][UFC_CTRL_ARTS];
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (
    !$past(req.rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside answer cycle");
  a_tx_select: assert property (
    age_r == 2'h3 |-> {tx_send_first, tx_send_second} == regs_r[0][3:2])
    else $error("tx pair select differs");
  a_pres_mirror: assert property (
    age_r == 2'h3 |-> clock_prescaler == regs_r[5][3:0])
    else $error("prescaler output differs");
  a_txc_level: assert property (
    m128 && tx_fill <= txl |=> tx_irq_cond)
    else $error("tx level condition missing");
  a_rxc_set: assert property (
    m128 && rx_fill >= rxl |=> rx_irq_cond)
    else $error("rx level condition missing");
  a_rts_set: assert property (
    m128 && arts && rx_fill > rxl |=> rts_req)
    else $error("request output not raised");
  a_rts_clear: assert property (
    m128 && arts && {1'b0, rx_fill} + 9'h001 < {1'b0, rxl} |=> !rts_req)
    else $error("request output not lowered");
  a_pause_hit: assert property (
    rx_char_vld && regs_r[0][1:0] == 2'b10 && rx_char == regs_r[8][7:0]
    |=> local_tx_paused)
    else $error("pause character missed");
  c_paused: cover property (local_tx_paused);
  c_rts: cover property (rts_req);
  c_flow_pulse: cover property (remote_pause_req);
endmodule // ufc_chk

// [verif/ufc_remote.sv]
// remote serial device model feeding the received character stream
`timescale 1ns/1ps
module ufc_remote (
  // clock
  input  wire logic clk,
  // received character stream
  output logic      rx_char_vld,
  output logic [7:0] rx_char
);
  initial begin
    rx_char_vld = 1'b0;
    rx_char     = 8'h00;
  end
  // one character after a gap; idle data inverted so it is never reused
  task automatic xmit(input logic [7:0] c, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rx_char_vld <= 1'b1;
    rx_char     <= c;
    @(posedge clk);
    rx_char_vld <= 1'b0;
    rx_char     <= ~c;
  endtask
  // payload never carries a flow character
  task automatic payload(input logic [7:0] f [4], input int gap);
    logic [7:0] c;
    c = 8'($urandom);
    while (c inside {f}) c = 8'($urandom);
    xmit(c, gap);
  endtask
endmodule // ufc_remote

// [verif/ufc_tb_top.sv]
// self-checking testbench for the uart flow control block
`timescale 1ns/1ps
module ufc_tb_top;
  import ufc_pkg::*;
  logic        clk, rst_n, irq, rx_char_vld;
  ufc_req_t    req;
  logic [31:0] rdata;
  logic        tx_send_first, tx_send_second, tx_irq_cond, rx_irq_cond;
  logic        remote_pause_req, remote_resume_req, local_tx_paused, rts_req;
  logic [7:0]  tx_fill, rx_fill, rx_char;
  logic [3:0]  clock_prescaler;
  int          errors, tests_run;
  logic [7:0]  fc [4] = '{8'h11, 8'h12, 8'h13, 8'h14};
  ufc_top ufc_top_i (.clk, .rst_n, .req, .rdata, .irq, .tx_fill, .rx_fill,
    .rx_char_vld, .rx_char, .tx_send_first, .tx_send_second,
    .clock_prescaler, .tx_irq_cond, .rx_irq_cond, .remote_pause_req,
    .remote_resume_req, .local_tx_paused, .rts_req);
  ufc_remote ufc_remote_i (.clk, .rx_char_vld, .rx_char);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // host bus cycles, one strobe cycle each
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic fill(input logic [7:0] t, r);
    @(posedge clk);
    tx_fill <= t;
    rx_fill <= r;
    tick(2);
  endtask
  // bounded wait for a flow character request
  task automatic await(input string n, input bit p);
    int k;
    for (k = 0; k < 8 && !(p ? remote_pause_req : remote_resume_req); k++)
      tick(1);
    chk(n, 1'h1, p ? remote_pause_req : remote_resume_req);
    if (k == 8) print_verdict();
  endtask
  function automatic logic [7:0] lv(input logic [7:0] v);
    return v == 8'h00 ? 8'h01 : (v > 8'h80 ? 8'h80 : v);
  endfunction
  initial begin
    logic [31:0] d;
    logic [7:0]  l;
    static logic [7:0]  lvls [6] =
      '{8'h00, 8'h01, 8'h40, 8'h80, 8'h81, 8'hFF};
    static logic [15:0] rts_tab [4] =
      '{16'h2000, 16'h2101, 16'h1F01, 16'h1E00};
    static logic [31:0] ctab [4] = '{32'h0A14_1311, 32'h0513_1412,
                              32'h0B00_1411, 32'h0700_1312};
    {rst_n, tx_fill, rx_fill, errors, tests_run} = '0;
    req = '0;
    void'($urandom(5197));
    lvls[2] = 8'($urandom_range(127, 2));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd("reset", 8'(a * 4), 0);
    for (int a = 1; a < 6; a++) begin
      d = $urandom;
      wr(8'(a * 4), d);
      rd("reg", 8'(a * 4), a == 5 ? d[3:0] : d[7:0]);
    end
    wr(8'h3C, 32'hFFFF_FFFF);
    rd("unmapped", 8'h3C, 0);
    $display("test registers done");
    wr(UFC_OFS_CTRL, 32'h0000_0001);
    foreach (lvls[i]) begin
      l = lv(lvls[i]);
      wr(UFC_OFS_TXLVL, lvls[i]);
      wr(UFC_OFS_RXLVL, lvls[i]);
      fill(l, l - 8'h01);
      chk("tx at level", 1'h1, tx_irq_cond);
      chk("rx below", 1'h0, rx_irq_cond);
      fill(l + 8'h01, l);
      chk("tx above", 1'h0, tx_irq_cond);
      chk("rx at level", 1'h1, rx_irq_cond);
    end
    wr(UFC_OFS_CTRL, 32'h0000_0000);
    wr(UFC_OFS_FCRLVL, 32'h0000_1000);
    wr(UFC_OFS_RXLVL, 32'h0000_0040);
    fill(8'h00, 8'h20);
    chk("rx small fifo", 1'h1, rx_irq_cond);
    $display("test levels done");
    wr(UFC_OFS_CTRL, 32'h0000_0003);
    wr(UFC_OFS_RXLVL, 32'h0000_0020);
    foreach (rts_tab[i]) begin
      fill(8'h00, rts_tab[i][15:8]);
      chk("rts", rts_tab[i][0], rts_req);
    end
    // flow thresholds: held at high, released at low
    wr(UFC_OFS_FEAT, 32'h0000_0008);
    wr(UFC_OFS_FHIGH, 32'h0000_0030);
    wr(UFC_OFS_FLOW, 32'h0000_0010);
    fill(8'h00, 8'h00);
    wr(UFC_OFS_ISTAT, 32'h0000_001F);
    wr(UFC_OFS_IMASK, 32'h0000_0010);
    fill(8'h00, 8'h2F);
    chk("irq idle", 1'h0, irq);
    @(posedge clk) rx_fill <= 8'h30;
    await("pause req", 1'b1);
    rd("held", UFC_OFS_STATE, 32'h0000_0005);
    chk("irq raised", 1'h1, irq);
    wr(UFC_OFS_IMASK, 32'h0000_0000);
    tick(1);
    chk("irq masked", 1'h0, irq);
    wr(UFC_OFS_IMASK, 32'h0000_0010);
    wr(UFC_OFS_ISTAT, 32'h0000_0010);
    tick(1);
    chk("irq cleared", 1'h0, irq);
    fill(8'h00, 8'h11);
    rd("still held", UFC_OFS_STATE, 32'h0000_0001);
    @(posedge clk) rx_fill <= 8'h10;
    await("resume req", 1'b0);
    $display("test flow done");
    for (int i = 0; i < 4; i++) wr(UFC_OFS_CHAR0 + 8'(i * 4), fc[i]);
    foreach (ctab[i]) begin
      wr(UFC_OFS_FEAT, ctab[i][27:24]);
      tick(2);
      chk("tx pair", ctab[i][27:26], {tx_send_first, tx_send_second});
      if (ctab[i][23:16] == 8'h00) ufc_remote_i.payload(fc, 0);
      else ufc_remote_i.xmit(ctab[i][23:16], 0);
      tick(1);
      chk("other char", 1'h0, local_tx_paused);
      ufc_remote_i.xmit(ctab[i][15:8], $urandom_range(3, 0));
      ufc_remote_i.payload(fc, 1);
      tick(1);
      chk("pause char", 1'h1, local_tx_paused);
      ufc_remote_i.xmit(ctab[i][7:0], 0);
      tick(1);
      chk("resume char", 1'h0, local_tx_paused);
    end
    wr(UFC_OFS_FEAT, 32'h0000_000F);
    ufc_remote_i.xmit(fc[2], 0);
    ufc_remote_i.payload(fc, 0);
    ufc_remote_i.xmit(fc[3], 0);
    tick(1);
    chk("split pair", 1'h0, local_tx_paused);
    chk("both pairs", 2'h3, {tx_send_first, tx_send_second});
    ufc_remote_i.xmit(fc[2], 0);
    ufc_remote_i.xmit(fc[3], 2);
    ufc_remote_i.xmit(fc[0], 0);
    tick(1);
    chk("half resume", 1'h1, local_tx_paused);
    ufc_remote_i.xmit(fc[1], 0);
    tick(1);
    chk("whole resume", 1'h0, local_tx_paused);
    $display("test characters done");
    print_verdict();
  end
endmodule // ufc_tb_top
bind ufc_top ufc_chk ufc_chk_i (.clk, .rst_n, .req, .rdata, .tx_fill,
  .rx_fill, .rx_char_vld, .rx_char, .tx_send_first, .tx_send_second,
  .clock_prescaler, .tx_irq_cond, .rx_irq_cond, .local_tx_paused,
  .rts_req, .remote_pause_req);
